/* hw/standby_pkg.sv */
// standby control constants shared by the standby controller and the core end
// assumes a single 25 MHz pclk domain
package standby_pkg;

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned INTOSC_HZ       = 240_000;
    localparam int unsigned INTOSC_WAKE_PER = 17;
    // hold after stop release on internal clock, rounded up
    localparam int unsigned INTOSC_WAKE_CYC =
        (INTOSC_WAKE_PER * CLK_HZ + INTOSC_HZ - 1) / INTOSC_HZ;
    localparam int unsigned WAKE_CNT_W      = 12;

    // ------------------------------------------------------------
    // cpu clock sources and modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_MAIN = 2'b00,
        SRC_INT  = 2'b01,
        SRC_SUB  = 2'b10,
        SRC_RSVD = 2'b11
    } clk_src_e;

    typedef enum logic [1:0] {
        MODE_RUN  = 2'b00,
        MODE_HALT = 2'b01,
        MODE_STOP = 2'b10,
        MODE_WAIT = 2'b11
    } mode_e;

    // ------------------------------------------------------------
    // stabilization status and wait select
    // ------------------------------------------------------------
    localparam int unsigned STAB_BITS      = 5;
    localparam int unsigned STAB_CNT_W     = 17;
    localparam int unsigned WAIT_SEL_W     = 3;
    localparam int unsigned STAB_BASE_BITS = 11;
    localparam logic [WAIT_SEL_W-1:0] WAIT_SEL_RST = 3'h4;

    // ------------------------------------------------------------
    // core-side register map (apb, word aligned)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam int unsigned CTRL_STOP    = 0;
    localparam int unsigned CTRL_HALT    = 1;
    localparam int unsigned CTRL_SRC_LO  = 2;
    localparam int unsigned CTRL_SEL_LO  = 4;
    localparam int unsigned CTRL_IOSTOP  = 7;
    localparam int unsigned CTRL_CONV    = 8;
    localparam int unsigned STAT_MODE_LO = 5;
    localparam int unsigned STAT_REFUSED = 7;
    localparam int unsigned STAT_HOLD    = 8;
    localparam int unsigned STAT_BUSY    = 9;
    localparam int unsigned STAT_CMDPEND = 10;

    // exponent of the stabilization step for a status bit
    function automatic int unsigned stab_exp(input int unsigned base, input int unsigned idx);
        stab_exp = (idx == 0) ? base : base + idx + 1;
    endfunction

endpackage

/* hw/standby_if.sv */
// link between the processor core end and the standby controller
// assumes both ends run on the same pclk
`timescale 1ns/1ps
interface standby_if;
    import standby_pkg::*;

    logic                  stop_req;
    logic                  halt_req;
    clk_src_e              clk_src;
    logic [WAIT_SEL_W-1:0] wait_sel;
    logic                  internal_osc_stop_ctl;
    logic                  irq_pending;
    logic                  cpu_hold;
    mode_e                 mode;
    logic [STAB_BITS-1:0]  stabilization_status;
    logic                  stop_refused;
    logic                  stab_busy;

    modport dev (
        input  stop_req,
        input  halt_req,
        input  clk_src,
        input  wait_sel,
        input  internal_osc_stop_ctl,
        input  irq_pending,
        output cpu_hold,
        output mode,
        output stabilization_status,
        output stop_refused,
        output stab_busy
    );

    modport core (
        output stop_req,
        output halt_req,
        output clk_src,
        output wait_sel,
        output internal_osc_stop_ctl,
        output irq_pending,
        input  cpu_hold,
        input  mode,
        input  stabilization_status,
        input  stop_refused,
        input  stab_busy
    );

endinterface

/* hw/standby_ctl.sv */
// standby controller: stop and halt entry, oscillator gating, stabilization wait
// assumes commands arrive on pclk from the core end; main_osc_ok is an async pin
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module standby_ctl
    import standby_pkg::*;
#(
    parameter int unsigned STAB_BASE = STAB_BASE_BITS
)(
    input  wire logic pclk,
    input  wire logic presetn,
    standby_if.dev    sif,
    input  wire logic main_osc_ok,
    input  wire logic sw_stop_option,
    output logic      main_osc_en,
    output logic      int_osc_en
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_HALT  = 3'b001,
        ST_STOP  = 3'b010,
        ST_STAB  = 3'b011,
        ST_IWAKE = 3'b100
    } st_e;

    st_e                   st_r;
    st_e                   st_nxt;
    logic                  osc_meta_r;
    logic                  osc_sync_r;
    logic                  option_meta_r;
    logic                  option_r;
    logic [WAIT_SEL_W-1:0] sel_r;
    logic [STAB_CNT_W-1:0] cnt_r;
    logic                  cnt_act_r;
    logic [STAB_BITS-1:0]  status_r;
    logic [WAKE_CNT_W-1:0] wake_r;
    logic                  main_en_r;
    logic                  int_en_r;
    logic                  refused_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [STAB_CNT_W-1:0] thr(input int unsigned idx);
        thr = STAB_CNT_W'(1) << stab_exp(STAB_BASE, idx);
    endfunction

    function automatic int unsigned sel_idx(input logic [WAIT_SEL_W-1:0] s);
        sel_idx = (s > 3'h4) ? 4 : int'(s);
    endfunction

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire src_sub     = (sif.clk_src == SRC_SUB);
    wire src_int     = (sif.clk_src == SRC_INT);
    wire stop_ok     = ~src_sub && (sif.clk_src != SRC_RSVD);
    wire start_stop  = (st_r == ST_RUN) && sif.stop_req && stop_ok;
    wire refuse_stop = (st_r == ST_RUN) && sif.stop_req && ~stop_ok;
    wire [STAB_CNT_W-1:0] limit = thr(sel_idx(sel_r));
    wire cnt_done    = (cnt_r >= limit);
    wire sel_done    = status_r[sel_idx(sel_r)];
    wire wake_done   = (wake_r == WAKE_CNT_W'(INTOSC_WAKE_CYC - 1));

    logic [STAB_BITS-1:0] status_nxt;
    always_comb
    begin
        status_nxt = status_r;
        // sticky, set in order as count climbs
        for (int k = 0; k < STAB_BITS; k++)
        begin
            if (cnt_r >= thr(k))
            begin
                status_nxt[k] = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // mode sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        st_nxt = st_r;
        unique case (st_r)
            ST_RUN:
            begin
                // pending interrupt drops stop straight into the stabilization wait
                if (start_stop && sif.irq_pending)
                begin
                    st_nxt = ST_STAB;
                end
                else if (start_stop)
                begin
                    st_nxt = ST_STOP;
                end
                else if (sif.halt_req)
                begin
                    st_nxt = ST_HALT;
                end
            end
            ST_HALT:
            begin
                if (sif.irq_pending)
                begin
                    st_nxt = ST_RUN;
                end
            end
            ST_STOP:
            begin
                if (sif.irq_pending)
                begin
                    st_nxt = src_int ? ST_IWAKE : ST_STAB;
                end
            end
            ST_STAB:
            begin
                if (sel_done)
                begin
                    st_nxt = ST_RUN;
                end
            end
            ST_IWAKE:
            begin
                if (wake_done)
                begin
                    st_nxt = ST_RUN;
                end
            end
            default:
            begin
                st_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r       <= ST_RUN;
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            option_meta_r <= 1'b0;
            option_r   <= 1'b0;
            refused_r  <= 1'b0;
        end
        else
        begin
            st_r       <= st_nxt;
            osc_meta_r <= main_osc_ok;
            osc_sync_r <= osc_meta_r;
            // option strap is a pin: two flops before use
            option_meta_r <= sw_stop_option;
            option_r      <= option_meta_r;
            refused_r  <= refuse_stop;
        end
    end

    // ------------------------------------------------------------
    // stabilization counter
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_r     <= WAIT_SEL_RST;
            cnt_r     <= '0;
            cnt_act_r <= 1'b0;
            status_r  <= '0;
        end
        else if (start_stop)
        begin
            // restart status from zero at stop entry
            sel_r     <= sif.wait_sel;
            cnt_r     <= '0;
            cnt_act_r <= 1'b1;
            status_r  <= '0;
        end
        else
        begin
            status_r <= status_nxt;
            // count only once the main oscillator runs
            if (cnt_act_r && st_r != ST_STOP && osc_sync_r && !cnt_done)
            begin
                cnt_r <= cnt_r + STAB_CNT_W'(1);
            end
            // counting ends at the selected length
            if (cnt_done)
            begin
                cnt_act_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_r <= '0;
        end
        else if (st_r == ST_IWAKE)
        begin
            wake_r <= wake_r + WAKE_CNT_W'(1);
        end
        else
        begin
            wake_r <= '0;
        end
    end

    // ------------------------------------------------------------
    // oscillator enables
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_en_r <= 1'b1;
            int_en_r  <= 1'b1;
        end
        else
        begin
            // stop gates only the main oscillator
            main_en_r <= (st_nxt != ST_STOP);
            // a running internal osc survives stop
            int_en_r  <= ~(sif.internal_osc_stop_ctl && option_r && !src_int);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign main_osc_en              = main_en_r;
    assign int_osc_en               = int_en_r;
    assign sif.cpu_hold             = (st_r != ST_RUN);
    assign sif.stabilization_status = status_r;
    assign sif.stop_refused         = refused_r;
    assign sif.stab_busy            = cnt_act_r;
    assign sif.mode = (st_r == ST_RUN)  ? MODE_RUN  :
                      (st_r == ST_HALT) ? MODE_HALT :
                      (st_r == ST_STOP) ? MODE_STOP : MODE_WAIT;

endmodule

/* hw/standby_core.sv */
// core end: apb registers that issue standby commands and report status
// assumes apb master on pclk; periph_idle and irq_in come from logic on pclk
`timescale 1ns/1ps
module standby_core
    import standby_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        irq_in,
    input  wire logic        periph_idle,
    output logic             converter_run_bit,
    standby_if.core          sif
);

    clk_src_e              src_r;
    logic [WAIT_SEL_W-1:0] sel_r;
    logic                  iostop_r;
    logic                  conv_r;
    logic                  stop_pend_r;
    logic                  halt_pend_r;
    logic                  stop_r;
    logic                  halt_r;
    logic                  refused_r;
    logic [31:0]           rdata_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup   = psel && !penable;
    wire access  = psel && penable;
    wire hit_ctl = (paddr == OFS_CTRL);
    wire hit_st  = (paddr == OFS_STATUS);
    wire wr_ctl  = access && pwrite && hit_ctl;
    wire wr_st   = access && pwrite && hit_st;
    // select changes only once the wait is over
    wire sel_ok  = !sif.stab_busy && (sif.mode == MODE_RUN);
    wire [31:0] ctl_view = {23'h0, conv_r, iostop_r, sel_r, src_r, 2'h0};
    wire [31:0] st_view  = {21'h0, stop_pend_r | halt_pend_r, sif.stab_busy,
                            sif.cpu_hold, refused_r, sif.mode, sif.stabilization_status};
    wire go_stop = stop_pend_r && periph_idle && !conv_r && !sif.cpu_hold;
    wire go_halt = halt_pend_r && !stop_pend_r && !conv_r && !sif.cpu_hold;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            src_r       <= SRC_MAIN;
            sel_r       <= WAIT_SEL_RST;
            iostop_r    <= 1'b0;
            conv_r      <= 1'b0;
            stop_pend_r <= 1'b0;
            halt_pend_r <= 1'b0;
        end
        else if (wr_ctl)
        begin
            src_r    <= clk_src_e'(pwdata[CTRL_SRC_LO +: 2]);
            iostop_r <= pwdata[CTRL_IOSTOP];
            // select latched before the stop goes out
            if (sel_ok)
            begin
                sel_r <= pwdata[CTRL_SEL_LO +: WAIT_SEL_W];
            end
            conv_r      <= pwdata[CTRL_CONV] && !pwdata[CTRL_STOP] && !pwdata[CTRL_HALT];
            stop_pend_r <= stop_pend_r | pwdata[CTRL_STOP];
            halt_pend_r <= halt_pend_r | pwdata[CTRL_HALT];
        end
        else
        begin
            if (go_stop)
            begin
                stop_pend_r <= 1'b0;
            end
            if (go_halt)
            begin
                halt_pend_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stop_r    <= 1'b0;
            halt_r    <= 1'b0;
            refused_r <= 1'b0;
            rdata_r   <= '0;
        end
        else
        begin
            stop_r    <= go_stop;
            halt_r    <= go_halt;
            // set wins over write-one-to-clear
            refused_r <= sif.stop_refused | (refused_r & ~(wr_st & pwdata[STAT_REFUSED]));
            if (setup)
            begin
                rdata_r <= hit_ctl ? ctl_view : (hit_st ? st_view : 32'h0);
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata                    = rdata_r;
    assign pready                    = 1'b1;
    assign pslverr                   = access && !hit_ctl && !hit_st;
    assign converter_run_bit         = conv_r;
    assign sif.stop_req              = stop_r;
    assign sif.halt_req              = halt_r;
    assign sif.clk_src               = src_r;
    assign sif.wait_sel              = sel_r;
    assign sif.internal_osc_stop_ctl = iostop_r;
    assign sif.irq_pending           = irq_in;

endmodule

/* verification/standby_monitor.sv */
// checker for the standby link between the core end and the controller
// assumes one pclk domain; instantiated beside the interface, no bind
`timescale 1ns/1ps
module standby_monitor
    import standby_pkg::*;
(
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 stop_req,
    input wire logic                 halt_req,
    input wire clk_src_e             clk_src,
    input wire logic [WAIT_SEL_W-1:0] wait_sel,
    input wire logic                 irq_pending,
    input wire logic                 cpu_hold,
    input wire mode_e                mode,
    input wire logic [STAB_BITS-1:0] stabilization_status,
    input wire logic                 stop_refused,
    input wire logic                 main_osc_ok,
    input wire logic                 sw_stop_option,
    input wire logic                 main_osc_en,
    input wire logic                 int_osc_en
);
    localparam int LO = INTOSC_WAKE_CYC - 1;
    localparam int HI = INTOSC_WAKE_CYC + 1;
    logic        int_wake_r;
    logic [11:0] wake_cnt_r;
    wire  [4:0]  sel_mask     = (wait_sel >= 3'h4) ? 5'h1f : (5'h02 << wait_sel) - 5'h01;
    wire  [4:0]  sel_top      = sel_mask ^ (sel_mask >> 1);
    wire         int_wake_nxt = (mode == MODE_STOP && clk_src == SRC_INT)
                              | (int_wake_r && mode != MODE_RUN);
    wire  [11:0] wake_cnt_nxt = (int_wake_r && mode == MODE_WAIT) ? wake_cnt_r + 12'h001 : 12'h000;

    // ------------------------------------------------------------
    // wake counter after an internal-clock stop
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_wake_r <= 1'b0;
            wake_cnt_r <= 12'h000;
        end
        else
        begin
            int_wake_r <= int_wake_nxt;
            wake_cnt_r <= wake_cnt_nxt;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_stop_bad;  stop_req && mode == MODE_RUN && clk_src[1]; endsequence
    sequence s_stop_good; stop_req && mode == MODE_RUN && !clk_src[1]; endsequence

    property p_refuse; s_stop_bad |=> stop_refused && mode == MODE_RUN; endproperty
    a_refuse: assert property (p_refuse) else $error("stop on sub clock not refused");
    property p_halt; halt_req && !stop_req && mode == MODE_RUN |=> mode == MODE_HALT; endproperty
    a_halt: assert property (p_halt) else $error("halt not entered");
    property p_entry; s_stop_good ##0 !irq_pending |=> mode == MODE_STOP && stabilization_status == 5'h00;
    endproperty
    a_entry: assert property (p_entry) else $error("stop entry wrong");
    property p_pend; s_stop_good ##0 irq_pending |=> mode == MODE_WAIT; endproperty
    a_pend: assert property (p_pend) else $error("pending stop not turned to wait");
    property p_osc; mode == MODE_STOP |-> !main_osc_en && (clk_src != SRC_INT || int_osc_en); endproperty
    a_osc: assert property (p_osc) else $error("oscillator enables wrong in stop");
    property p_option; (!sw_stop_option)[*4] |-> int_osc_en; endproperty
    a_option: assert property (p_option) else $error("internal osc stopped without option");
    property p_wake_max; int_wake_r |-> wake_cnt_r <= HI; endproperty
    a_wake_max: assert property (p_wake_max) else $error("internal wake too long");
    property p_wake_min; int_wake_r && mode == MODE_RUN && wake_cnt_r != 0 |-> wake_cnt_r >= LO;
    endproperty
    a_wake_min: assert property (p_wake_min) else $error("internal wake too short");
    property p_order; ((stabilization_status + 5'h01) & stabilization_status) == 5'h00; endproperty
    a_order: assert property (p_order) else $error("status bits out of order");
    property p_sticky; mode == $past(mode) |->
        (stabilization_status & $past(stabilization_status)) == $past(stabilization_status);
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped");
    property p_limit; mode == MODE_WAIT |-> (stabilization_status & ~sel_mask) == 5'h00; endproperty
    a_limit: assert property (p_limit) else $error("status beyond selected wait");
    property p_done; mode == MODE_WAIT && !int_wake_r && (stabilization_status & sel_top) != 5'h00
        |=> mode == MODE_RUN;
    endproperty
    a_done: assert property (p_done) else $error("no run after selected wait");
    property p_no_osc; (mode == MODE_WAIT && !main_osc_ok)[*5] |-> $stable(stabilization_status);
    endproperty
    a_no_osc: assert property (p_no_osc) else $error("counted before oscillation");
    property p_hold; cpu_hold == (mode != MODE_RUN); endproperty
    a_hold: assert property (p_hold) else $error("cpu hold disagrees with mode");
endmodule

/* verification/standby_oscillation_stabilization_tb.sv */
// self-checking bench: apb core end and standby controller joined by the link
// assumes standby_monitor watches the link signals
`timescale 1ns/1ps
module standby_oscillation_stabilization_tb;
    import standby_pkg::*;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_in;
    logic        periph_idle;
    logic        converter_run_bit;
    logic        main_osc_ok;
    logic        sw_stop_option;
    logic        main_osc_en;
    logic        int_osc_en;
    logic [31:0] q;
    logic        err;
    int          failures;
    int          n_compared;
    int          n;
    int          seed;

    standby_if sif ();
    standby_core i_standby_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_in(irq_in), .periph_idle(periph_idle),
        .converter_run_bit(converter_run_bit), .sif(sif.core));
    standby_ctl #(.STAB_BASE(2)) i_standby_ctl (.pclk(pclk), .presetn(presetn), .sif(sif.dev),
        .main_osc_ok(main_osc_ok), .sw_stop_option(sw_stop_option), .main_osc_en(main_osc_en),
        .int_osc_en(int_osc_en));
    standby_monitor i_standby_monitor (.pclk(pclk), .presetn(presetn), .stop_req(sif.stop_req),
        .halt_req(sif.halt_req), .clk_src(sif.clk_src), .wait_sel(sif.wait_sel),
        .irq_pending(sif.irq_pending), .cpu_hold(sif.cpu_hold), .mode(sif.mode),
        .stabilization_status(sif.stabilization_status), .stop_refused(sif.stop_refused),
        .main_osc_ok(main_osc_ok), .sw_stop_option(sw_stop_option), .main_osc_en(main_osc_en),
        .int_osc_en(int_osc_en));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] cw(input logic s, input logic h, input logic [1:0] src,
                                       input logic [2:0] sel, input logic io, input logic cv);
        return {23'h0, cv, io, sel, src, h, s};
    endfunction

    function automatic logic [4:0] exp_stat(input logic [2:0] sel);
        return (sel >= 3'h4) ? 5'h1f : (5'h02 << sel) - 5'h01;
    endfunction

    task automatic wait_mode(input mode_e m);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (sif.mode !== m && n < 4000);
        chk(32'(sif.mode), 32'(m));
    endtask

    // stop with peripherals busy first, then wake by interrupt
    task automatic stop_seq(input logic [1:0] src, input logic [2:0] sel, input logic io);
        apb(1'b1, OFS_CTRL, cw(1'b0, 1'b0, src, sel, io, 1'b1));
        periph_idle <= 1'b0;
        @(negedge pclk);
        chk(32'(converter_run_bit), 32'h1);
        apb(1'b1, OFS_CTRL, cw(1'b1, 1'b0, src, sel, io, 1'b1));
        repeat (4) @(negedge pclk);
        chk(32'(sif.mode), 32'(MODE_RUN));
        chk(32'(converter_run_bit), 32'h0);
        @(posedge pclk);
        periph_idle <= 1'b1;
        wait_mode(MODE_STOP);
        chk(32'(sif.stabilization_status), 32'h0);
        chk(32'(main_osc_en), 32'h0);
        chk(32'(int_osc_en), 32'h1);
        @(posedge pclk);
        main_osc_ok <= 1'b0;
        repeat (5 + $unsigned($random(seed)) % 16) @(posedge pclk);
        irq_in <= 1'b1;
        wait_mode(MODE_WAIT);
        @(posedge pclk);
        irq_in <= 1'b0;
        if (src != SRC_INT)
            repeat (5 + $unsigned($random(seed)) % 16) @(posedge pclk);
        main_osc_ok <= 1'b1;
        wait_mode(MODE_RUN);
        if (src == SRC_INT)
            chk(32'(n >= INTOSC_WAKE_CYC - 3 && n <= INTOSC_WAKE_CYC + 1), 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(q[4:0]), 32'(exp_stat(sel)));
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial
    begin
        repeat (40000) @(posedge pclk);
        failures++;
        summarize();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        seed = 32'h49873ebe;
        failures = 0;
        n_compared = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_in, sw_stop_option} = '0;
        periph_idle = 1'b1;
        main_osc_ok = 1'b1;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFS_CTRL, 32'h0);
        chk(q, 32'h40);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk(q, 32'h0);
        chk(32'(err), 32'h1);
        apb(1'b1, OFS_CTRL, cw(1'b0, 1'b0, SRC_MAIN, 3'h4, 1'b1, 1'b0));
        repeat (6) @(negedge pclk);
        chk(32'(int_osc_en), 32'h1);
        @(posedge pclk);
        sw_stop_option <= 1'b1;
        repeat (6) @(negedge pclk);
        chk(32'(int_osc_en), 32'h0);
        apb(1'b1, OFS_CTRL, cw(1'b0, 1'b0, SRC_MAIN, 3'h4, 1'b0, 1'b0));
        repeat (6) @(negedge pclk);
        chk(32'(int_osc_en), 32'h1);
        apb(1'b1, OFS_CTRL, cw(1'b1, 1'b0, SRC_SUB, 3'h4, 1'b0, 1'b0));
        // refusal pulse reaches the sticky bit a few edges later
        repeat (4) @(posedge pclk);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(q[7:5]), 32'h4);
        apb(1'b1, OFS_STATUS, 32'h80);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(q[7]), 32'h0);
        apb(1'b1, OFS_CTRL, cw(1'b0, 1'b1, SRC_SUB, 3'h4, 1'b0, 1'b0));
        wait_mode(MODE_HALT);
        @(posedge pclk);
        irq_in <= 1'b1;
        wait_mode(MODE_RUN);
        @(posedge pclk);
        irq_in <= 1'b0;
        for (int i = 0; i < 6; i++)
            stop_seq(SRC_MAIN, (i < 5) ? 3'(i) : 3'(5 + $unsigned($random(seed)) % 3), 1'b0);
        stop_seq(SRC_INT, 3'h4, 1'b1);
        @(posedge pclk);
        irq_in <= 1'b1;
        apb(1'b1, OFS_CTRL, cw(1'b1, 1'b0, SRC_MAIN, 3'h1, 1'b0, 1'b0));
        wait_mode(MODE_WAIT);
        wait_mode(MODE_RUN);
        apb(1'b0, OFS_STATUS, 32'h0);
        irq_in <= 1'b0;
        chk(32'(q[4:0]), 32'(exp_stat(3'h1)));
        summarize();
    end
endmodule
